// [scu_frame_rx.sv]
`timescale 1ns/1ps
module scu_frame_rx (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Synchronised line
   input wire logic line_i,
   // Control
   input wire logic measure_i,
   input wire logic [scu_pkg::PER_W-1:0] period_i,
   // Result
   output logic done_o,
   output logic err_o,
   output logic [7:0] data_o,
   output logic [scu_pkg::PER_W-1:0] period_o,
   output logic busy_o
);
   scu_pkg::scu_rx_state_t st_reg;
   logic line_q;
   logic fall;
   logic [scu_pkg::PER_W-1:0] cnt_reg;
   logic [2:0] falls_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic ferr_reg;
   logic [scu_pkg::PER_W-1:0] high_reg;

   assign fall = line_q & ~line_i;
   assign busy_o = (st_reg != scu_pkg::RX_IDLE);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         line_q <= 1'b1;
      end else begin
         line_q <= line_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg <= scu_pkg::RX_IDLE;
         cnt_reg <= '0;
         falls_reg <= 3'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         ferr_reg <= 1'b0;
         high_reg <= '0;
         period_o <= '0;
         done_o <= 1'b0;
         err_o <= 1'b0;
         data_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         case (st_reg)
            scu_pkg::RX_IDLE: begin
               ferr_reg <= 1'b0;
               if (fall && measure_i) begin
                  cnt_reg <= '0;
                  high_reg <= '0;
                  falls_reg <= 3'h0;
                  st_reg <= scu_pkg::RX_MEAS;
               end else if (fall) begin
                  cnt_reg <= {1'b0, period_i[scu_pkg::PER_W-1:1]};
                  period_o <= period_i;
                  bit_reg <= scu_pkg::BIT_START;
                  st_reg <= scu_pkg::RX_SAMP;
               end
            end
            scu_pkg::RX_MEAS: begin
               cnt_reg <= cnt_reg + 1'b1;
               high_reg <= line_i ? high_reg + 1'b1 : '0;
               if (&cnt_reg) begin
                  st_reg <= scu_pkg::RX_IDLE;
               end else if (line_i && high_reg > (cnt_reg >> 1) + (cnt_reg >> 3)) begin
                  // High run too long for a sync byte: hunt for a fresh start edge
                  st_reg <= scu_pkg::RX_IDLE;
               end else if (fall && falls_reg == scu_pkg::SYNC_FALLS) begin
                  // Eight bit times from start edge to the D7 edge
                  period_o <= (cnt_reg + 1'b1) >> 3;
                  cnt_reg <= (cnt_reg + 1'b1) >> 4;
                  sh_reg <= scu_pkg::SYNC_PRELOAD;
                  bit_reg <= scu_pkg::BIT_D7;
                  st_reg <= scu_pkg::RX_SAMP;
               end else if (fall) begin
                  falls_reg <= falls_reg + 1'b1;
               end
            end
            scu_pkg::RX_SAMP: begin
               if (cnt_reg == '0) begin
                  cnt_reg <= period_o - 1'b1;
                  bit_reg <= bit_reg + 1'b1;
                  if (bit_reg == scu_pkg::BIT_START) begin
                     ferr_reg <= line_i;
                  end else if (bit_reg <= scu_pkg::BIT_D7) begin
                     sh_reg <= {line_i, sh_reg[7:1]};
                  end else if (bit_reg == scu_pkg::BIT_PAR) begin
                     ferr_reg <= ferr_reg | (line_i != ^sh_reg);
                  end else begin
                     done_o <= 1'b1;
                     err_o <= ferr_reg | ~line_i;
                     data_o <= sh_reg;
                     st_reg <= scu_pkg::RX_IDLE;
                  end
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            default: st_reg <= scu_pkg::RX_IDLE;
         endcase
      end
   end
endmodule : scu_frame_rx

// [scu_frame_tx.sv]
`timescale 1ns/1ps
module scu_frame_tx (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Request
   input wire logic start_i,
   input wire logic [7:0] data_i,
   input wire logic [scu_pkg::PER_W-1:0] period_i,
   // Line side
   output logic busy_o,
   output logic drive_low_o
);
   logic [11:0] sh_reg;
   logic [3:0] bits_reg;
   logic [scu_pkg::PER_W-1:0] tmr_reg;

   assign drive_low_o = busy_o & ~sh_reg[0];

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sh_reg <= 12'hfff;
         bits_reg <= 4'h0;
         tmr_reg <= '0;
         busy_o <= 1'b0;
      end else if (start_i && !busy_o) begin
         // Leading idle bit gives the host a turnaround gap
         sh_reg <= {1'b1, ^data_i, data_i, 1'b0, 1'b1};
         bits_reg <= scu_pkg::TX_BITS;
         tmr_reg <= period_i - 1'b1;
         busy_o <= 1'b1;
      end else if (busy_o) begin
         if (tmr_reg == '0) begin
            tmr_reg <= period_i - 1'b1;
            sh_reg <= {1'b1, sh_reg[11:1]};
            bits_reg <= bits_reg - 1'b1;
            busy_o <= (bits_reg != 4'h1);
         end else begin
            tmr_reg <= tmr_reg - 1'b1;
         end
      end
   end
endmodule : scu_frame_tx

// [scu_host_model.sv]
`timescale 1ns/1ps
module scu_host_model #(
   parameter int BIT_CLKS = 16
) (
   // Clock
   input wire logic clk_i,
   // Pin
   input wire logic pin_i,
   output logic pull_low_o
);
   initial pull_low_o = 1'b0;

   task automatic send(input logic [7:0] b, input logic bad_par);
      logic [10:0] f;
      f = {1'b1, (^b) ^ bad_par, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         pull_low_o = ~f[i];
         repeat (BIT_CLKS) @(posedge clk_i);
         #1;
      end
   endtask : send

   // Line stays released while the device answers
   task automatic recv(output logic [7:0] b, output logic ok);
      logic [10:0] f;
      int n;
      n = 0;
      pull_low_o = 1'b0;
      while (pin_i !== 1'b0 && n < 8 * BIT_CLKS) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      #1;
      for (int i = 0; i < 11; i++) begin
         f[i] = pin_i;
         if (i < 10) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            #1;
         end
      end
      b = f[8:1];
      ok = n < 8 * BIT_CLKS && f[0] === 1'b0 && f[10] === 1'b1 && f[9] === ^f[8:1];
   endtask : recv
endmodule : scu_host_model

// [scu_pkg.sv]
package scu_pkg;
   // Bit timing
   localparam int PER_W = 16;
   localparam int GAP_W = 21;
   localparam int GAP_SHIFT = 4;
   localparam logic [3:0] BIT_START = 4'h0;
   localparam logic [3:0] BIT_D7 = 4'h8;
   localparam logic [3:0] BIT_PAR = 4'h9;
   localparam logic [3:0] BIT_STOP = 4'ha;
   localparam logic [3:0] TX_BITS = 4'hc;
   localparam logic [2:0] SYNC_FALLS = 3'h3;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam logic [7:0] SYNC_PRELOAD = 8'haa;
   // Register space
   localparam int SHADOW_DEPTH = 96;
   localparam int NV_DEPTH = 32;
   localparam int CUST_ID_BASE = 0;
   localparam logic [6:0] VIRT_BASE = 7'h60;
   localparam logic [6:0] ADDR_HANDOFF_FIRST = 7'h60;
   localparam logic [6:0] ADDR_HANDOFF_SECOND = 7'h61;
   localparam logic [6:0] ADDR_BURN_FIRST = 7'h62;
   localparam logic [6:0] ADDR_BURN_SECOND = 7'h63;
   localparam logic [7:0] KEY_FIRST = 8'h70;
   localparam logic [7:0] KEY_SECOND = 8'h51;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_MEAS = 3'b010,
      RX_SAMP = 3'b100
   } scu_rx_state_t;

   typedef enum logic [6:0] {
      ST_SYNC = 7'b0000001,
      ST_CMD  = 7'b0000010,
      ST_D1   = 7'b0000100,
      ST_D2   = 7'b0001000,
      ST_TX1  = 7'b0010000,
      ST_TX2  = 7'b0100000,
      ST_OPER = 7'b1000000
   } scu_state_t;
endpackage : scu_pkg

// [scu_single_wire_uart.sv]
`timescale 1ns/1ps
// Function
// - Comes up in communication mode on the output pin, driving it open-drain only.
// - A register access is four frames in a row on the line.
// - A frame is start bit, eight payload bits, parity bit, stop bit.
// - The parity bit gives even parity over the payload.
// - Payload goes least significant bit first.
// - The first frame is 0x55 with parity zero and sets the bit timing.
// - The second frame holds direction in bit 7 (1 read) and address in bits 6:0.
// - The third frame is the addressed byte and the fourth the next address up.
// - Writing 0x70 to 0x60 and 0x51 to 0x61 hands over to operational mode.
// - Once handed over the part stays operational and ignores the line.
// - Writing 0x70 to 0x62 and 0x51 to 0x63 burns the first 32 shadow values into one-time memory.
// - Four customer identifier bytes are writable and kept in one-time memory.
module scu_single_wire_uart (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Output pin, open-drain
   input wire logic line_i,
   output logic line_o,
   output logic line_oe_o,
   // Status
   output logic comm_mode_o,
   output logic otp_burn_o,
   output logic [31:0] cust_id_o
);
   scu_pkg::scu_state_t st_reg;
   logic line_m_reg;
   logic line_s_reg;
   logic rx_done;
   logic rx_err;
   logic rx_busy;
   logic [7:0] rx_data;
   logic [scu_pkg::PER_W-1:0] period;
   logic tx_busy;
   logic tx_drive;
   logic tx_start_reg;
   logic [7:0] tx_data_reg;
   logic [6:0] addr_reg;
   logic [7:0] d1_reg;
   logic wr_stb_reg;
   logic [6:0] wr_addr_reg;
   logic [7:0] wr_data_reg [2];
   logic [6:0] wb_addr [2];
   logic [7:0] shadow_mem [scu_pkg::SHADOW_DEPTH];
   logic [7:0] otp_mem [scu_pkg::NV_DEPTH];
   logic otp_written_reg;
   logic [7:0] hf_first_reg;
   logic [7:0] hf_second_reg;
   logic [7:0] bn_first_reg;
   logic [7:0] bn_second_reg;
   logic handoff_go;
   logic burn_go;
   logic [scu_pkg::GAP_W-1:0] gap_reg;
   logic [scu_pkg::GAP_W-1:0] gap_limit;
   logic gap_expired;
   logic waiting;

   function automatic logic [7:0] rd_byte(input logic [6:0] a);
      if (a < scu_pkg::VIRT_BASE) begin
         rd_byte = shadow_mem[a];
      end else begin
         rd_byte = 8'h00;
      end
   endfunction : rd_byte

   assign wb_addr[0] = wr_addr_reg;
   assign wb_addr[1] = wr_addr_reg + 7'h01;
   assign handoff_go = (hf_first_reg == scu_pkg::KEY_FIRST)
                     && (hf_second_reg == scu_pkg::KEY_SECOND);
   assign burn_go = (bn_first_reg == scu_pkg::KEY_FIRST)
                  && (bn_second_reg == scu_pkg::KEY_SECOND);
   assign waiting = (st_reg == scu_pkg::ST_CMD) || (st_reg == scu_pkg::ST_D1)
                  || (st_reg == scu_pkg::ST_D2);
   // Sixteen bit times at the learned rate
   assign gap_limit = {1'b0, period, {scu_pkg::GAP_SHIFT{1'b0}}};
   assign gap_expired = gap_reg > gap_limit;

   // Two-stage synchroniser on the pin
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         line_m_reg <= 1'b1;
         line_s_reg <= 1'b1;
      end else begin
         line_m_reg <= line_i;
         line_s_reg <= line_m_reg;
      end
   end

   scu_frame_rx u_rx (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .line_i(line_s_reg),
      .measure_i(st_reg == scu_pkg::ST_SYNC),
      .period_i(period),
      .done_o(rx_done),
      .err_o(rx_err),
      .data_o(rx_data),
      .period_o(period),
      .busy_o(rx_busy)
   );

   scu_frame_tx u_tx (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(tx_start_reg),
      .data_i(tx_data_reg),
      .period_i(period),
      .busy_o(tx_busy),
      .drive_low_o(tx_drive)
   );

   // Abandoned transaction guard: quiet line for sixteen bit times
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         gap_reg <= '0;
      end else if (!waiting || rx_busy) begin
         gap_reg <= '0;
      end else if (!gap_expired) begin
         gap_reg <= gap_reg + 1'b1;
      end
   end

   // Transaction sequencer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg <= scu_pkg::ST_SYNC;
         addr_reg <= 7'h00;
         d1_reg <= 8'h00;
         wr_stb_reg <= 1'b0;
         wr_addr_reg <= 7'h00;
         wr_data_reg[0] <= 8'h00;
         wr_data_reg[1] <= 8'h00;
         tx_start_reg <= 1'b0;
         tx_data_reg <= 8'h00;
      end else begin
         wr_stb_reg <= 1'b0;
         tx_start_reg <= 1'b0;
         if (handoff_go) begin
            st_reg <= scu_pkg::ST_OPER;
         end else begin
            case (st_reg)
               scu_pkg::ST_SYNC: begin
                  if (rx_done && !rx_err && rx_data == scu_pkg::SYNC_BYTE) begin
                     st_reg <= scu_pkg::ST_CMD;
                  end
               end
               scu_pkg::ST_CMD: begin
                  if (rx_done && rx_err) begin
                     st_reg <= scu_pkg::ST_SYNC;
                  end else if (rx_done) begin
                     addr_reg <= rx_data[6:0];
                     if (rx_data[7]) begin
                        tx_data_reg <= rd_byte(rx_data[6:0]);
                        tx_start_reg <= 1'b1;
                        st_reg <= scu_pkg::ST_TX1;
                     end else begin
                        st_reg <= scu_pkg::ST_D1;
                     end
                  end else if (gap_expired) begin
                     st_reg <= scu_pkg::ST_SYNC;
                  end
               end
               scu_pkg::ST_D1: begin
                  if (rx_done && rx_err) begin
                     st_reg <= scu_pkg::ST_SYNC;
                  end else if (rx_done) begin
                     d1_reg <= rx_data;
                     st_reg <= scu_pkg::ST_D2;
                  end else if (gap_expired) begin
                     st_reg <= scu_pkg::ST_SYNC;
                  end
               end
               scu_pkg::ST_D2: begin
                  if (rx_done) begin
                     // Both bytes land together only after a clean fourth frame
                     wr_stb_reg <= ~rx_err;
                     wr_addr_reg <= addr_reg;
                     wr_data_reg[0] <= d1_reg;
                     wr_data_reg[1] <= rx_data;
                     st_reg <= scu_pkg::ST_SYNC;
                  end else if (gap_expired) begin
                     st_reg <= scu_pkg::ST_SYNC;
                  end
               end
               scu_pkg::ST_TX1: begin
                  if (!tx_busy && !tx_start_reg) begin
                     tx_data_reg <= rd_byte(addr_reg + 7'h01);
                     tx_start_reg <= 1'b1;
                     st_reg <= scu_pkg::ST_TX2;
                  end
               end
               scu_pkg::ST_TX2: begin
                  if (!tx_busy && !tx_start_reg) begin
                     st_reg <= scu_pkg::ST_SYNC;
                  end
               end
               scu_pkg::ST_OPER: st_reg <= scu_pkg::ST_OPER;
               default: st_reg <= scu_pkg::ST_SYNC;
            endcase
         end
      end
   end

   // Shadow registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < scu_pkg::SHADOW_DEPTH; i++) begin
            shadow_mem[i] <= 8'h00;
         end
      end else if (wr_stb_reg) begin
         for (int i = 0; i < 2; i++) begin
            if (wb_addr[i] < scu_pkg::VIRT_BASE) begin
               shadow_mem[wb_addr[i]] <= wr_data_reg[i];
            end
         end
      end
   end

   // Burn key registers, cleared once their command fires
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bn_first_reg <= 8'h00;
         bn_second_reg <= 8'h00;
      end else begin
         if (burn_go) begin
            bn_first_reg <= 8'h00;
            bn_second_reg <= 8'h00;
         end
         // A key byte landing in the same cycle outlives the clear
         if (wr_stb_reg) begin
            for (int i = 0; i < 2; i++) begin
               if (wb_addr[i] == scu_pkg::ADDR_BURN_FIRST) begin
                  bn_first_reg <= wr_data_reg[i];
               end
               if (wb_addr[i] == scu_pkg::ADDR_BURN_SECOND) begin
                  bn_second_reg <= wr_data_reg[i];
               end
            end
         end
      end
   end

   // Handoff keys stay set: the mode change is final
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hf_first_reg <= 8'h00;
         hf_second_reg <= 8'h00;
      end else if (wr_stb_reg) begin
         for (int i = 0; i < 2; i++) begin
            if (wb_addr[i] == scu_pkg::ADDR_HANDOFF_FIRST) begin
               hf_first_reg <= wr_data_reg[i];
            end
            if (wb_addr[i] == scu_pkg::ADDR_HANDOFF_SECOND) begin
               hf_second_reg <= wr_data_reg[i];
            end
         end
      end
   end

   // One-time memory: no reset, it models fuses
   always_ff @(posedge clk_i) begin
      if (burn_go) begin
         for (int i = 0; i < scu_pkg::NV_DEPTH; i++) begin
            otp_mem[i] <= shadow_mem[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         otp_written_reg <= 1'b0;
         otp_burn_o <= 1'b0;
         cust_id_o <= 32'h0000_0000;
      end else begin
         otp_burn_o <= burn_go;
         if (burn_go) begin
            otp_written_reg <= 1'b1;
         end
         if (otp_written_reg) begin
            cust_id_o <= {otp_mem[scu_pkg::CUST_ID_BASE + 3], otp_mem[scu_pkg::CUST_ID_BASE + 2],
                          otp_mem[scu_pkg::CUST_ID_BASE + 1], otp_mem[scu_pkg::CUST_ID_BASE]};
         end
      end
   end

   // Pin driver: only ever pulls low
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         line_o <= 1'b0;
         line_oe_o <= 1'b0;
         comm_mode_o <= 1'b1;
      end else begin
         line_o <= 1'b0;
         line_oe_o <= tx_drive && (st_reg != scu_pkg::ST_OPER);
         comm_mode_o <= (st_reg != scu_pkg::ST_OPER);
      end
   end
endmodule : scu_single_wire_uart

// [scu_single_wire_uart_chk.sv]
`timescale 1ns/1ps
module scu_single_wire_uart_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Pin
   input wire logic line_i,
   input wire logic line_o,
   input wire logic line_oe_o,
   // Status
   input wire logic comm_mode_o,
   input wire logic otp_burn_o,
   input wire logic [31:0] cust_id_o
);
   // Longest device low (start, eight zeros, parity) plus one bit of slack, at 16 clocks a bit
   localparam int MAX_LOW = 176;
   logic [15:0] low_run;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !line_oe_o) begin
         low_run <= 16'h0000;
      end else begin
         low_run <= low_run + 16'h0001;
      end
   end

   sequence s_quiet;
      !line_oe_o [*8];
   endsequence
   sequence s_pulse;
      otp_burn_o ##1 !otp_burn_o;
   endsequence

   property p_pin_zero;
      line_o == 1'b0;
   endproperty
   property p_reset_vals;
      disable iff (1'b0)
      sys_rst_i |=> comm_mode_o && !line_oe_o && !otp_burn_o && cust_id_o == 32'h0;
   endproperty
   property p_oe_bounded;
      low_run < MAX_LOW;
   endproperty
   property p_stay_oper;
      !comm_mode_o |=> !comm_mode_o;
   endproperty
   property p_quiet_oper;
      $fell(comm_mode_o) |-> s_quiet;
   endproperty
   property p_burn_pulse;
      otp_burn_o |-> s_pulse;
   endproperty
   property p_burn_comm;
      otp_burn_o |-> comm_mode_o;
   endproperty
   property p_burn_idle;
      otp_burn_o |-> line_i && $past(line_i, 2);
   endproperty
   property p_id_on_burn;
      $changed(cust_id_o) |-> otp_burn_o || $past(otp_burn_o) || $past(otp_burn_o, 2);
   endproperty

   a_pin_zero: assert property (p_pin_zero) else $error("pin output not low");
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
   a_oe_bounded: assert property (p_oe_bounded) else $error("pin held low too long");
   a_stay_oper: assert property (p_stay_oper) else $error("left operational mode");
   a_quiet_oper: assert property (p_quiet_oper) else $error("pin driven after handoff");
   a_burn_pulse: assert property (p_burn_pulse) else $error("burn pulse too long");
   a_burn_comm: assert property (p_burn_comm) else $error("burn outside comm mode");
   a_burn_idle: assert property (p_burn_idle) else $error("burn before frame end");
   a_id_on_burn: assert property (p_id_on_burn) else $error("id changed without burn");
endmodule : scu_single_wire_uart_chk

bind scu_single_wire_uart scu_single_wire_uart_chk i_scu_single_wire_uart_chk (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .line_i(line_i), .line_o(line_o),
   .line_oe_o(line_oe_o), .comm_mode_o(comm_mode_o), .otp_burn_o(otp_burn_o),
   .cust_id_o(cust_id_o)
);

// [scu_single_wire_uart_test.sv]
`timescale 1ns/1ps
module scu_single_wire_uart_test;
   localparam int BIT_CLKS = 16;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic line_o;
   logic line_oe_o;
   logic comm_mode_o;
   logic otp_burn_o;
   logic [31:0] cust_id_o;
   logic pull_low;
   wire pin = ~(line_oe_o | pull_low);
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   int burns = 0;

   scu_single_wire_uart i_scu_single_wire_uart (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .line_i(pin), .line_o(line_o),
      .line_oe_o(line_oe_o), .comm_mode_o(comm_mode_o), .otp_burn_o(otp_burn_o),
      .cust_id_o(cust_id_o)
   );
   scu_host_model #(.BIT_CLKS(BIT_CLKS)) i_scu_host_model (
      .clk_i(clk_i), .pin_i(pin), .pull_low_o(pull_low)
   );

   always #10 clk_i = ~clk_i;

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   always @(posedge clk_i) begin
      cycles++;
      if (otp_burn_o === 1'b1) burns++;
      if (cycles == 40000) begin
         mismatches++;
         $display("mismatch at %0t: run too long", $time);
         close_out();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic gap();
      repeat (20 * BIT_CLKS) @(posedge clk_i);
      #1;
   endtask : gap

   // Fault 1 spoils the sync byte, fault 2 the parity of the third frame
   task automatic wr(input logic [6:0] a, input logic [7:0] d1, input logic [7:0] d2, input int bad);
      i_scu_host_model.send(bad == 1 ? 8'h54 : scu_pkg::SYNC_BYTE, 1'b0);
      i_scu_host_model.send({1'b0, a}, 1'b0);
      i_scu_host_model.send(d1, bad == 2);
      i_scu_host_model.send(d2, 1'b0);
      gap();
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [7:0] e1, input logic [7:0] e2,
                     input logic ok_e);
      logic [7:0] b;
      logic ok;
      i_scu_host_model.send(scu_pkg::SYNC_BYTE, 1'b0);
      i_scu_host_model.send({1'b1, a}, 1'b0);
      i_scu_host_model.recv(b, ok);
      chk(ok, ok_e, "first frame");
      if (ok_e) chk(b, e1, "first byte");
      i_scu_host_model.recv(b, ok);
      chk(ok, ok_e, "second frame");
      if (ok_e) chk(b, e2, "second byte");
      gap();
   endtask : rd

   initial begin
      repeat (8) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk(comm_mode_o, 1'b1, "mode after reset");
      chk(line_oe_o, 1'b0, "pin after reset");
      chk(cust_id_o, 32'h0, "id after reset");
      $display("test reset done");
      wr(7'h22, 8'h18, 8'ha2, 0);
      rd(7'h22, 8'h18, 8'ha2, 1'b1);
      rd(7'h23, 8'ha2, 8'h00, 1'b1);
      $display("test access done");
      wr(7'h22, 8'h33, 8'h44, 2);
      wr(7'h22, 8'h66, 8'h77, 1);
      rd(7'h22, 8'h18, 8'ha2, 1'b1);
      $display("test discard done");
      wr(7'h00, 8'h11, 8'h22, 0);
      wr(7'h02, 8'h33, 8'h44, 0);
      chk(cust_id_o, 32'h0, "id before burn");
      wr(7'h62, 8'h70, 8'h51, 0);
      chk(burns, 1, "first burn");
      chk(cust_id_o, 32'h44332211, "id after burn");
      wr(7'h62, 8'h70, 8'h00, 0);
      chk(burns, 1, "half key");
      wr(7'h63, 8'h51, 8'h00, 0);
      chk(burns, 2, "split key burn");
      rd(7'h00, 8'h11, 8'h22, 1'b1);
      $display("test burn done");
      wr(7'h60, 8'h70, 8'h51, 0);
      chk(comm_mode_o, 1'b0, "handoff");
      rd(7'h22, 8'h00, 8'h00, 1'b0);
      wr(7'h62, 8'h70, 8'h51, 0);
      chk(burns, 2, "burn after handoff");
      chk(comm_mode_o, 1'b0, "mode stays");
      $display("test handoff done");
      close_out();
   end
endmodule : scu_single_wire_uart_test
